// ---- hw/ocm_regs.svh ----
// Register offsets, field values, reset values and timing counts of the
// operating mode controller. Assumes inclusion by its bare name.
`ifndef OCM_REGS_SVH
`define OCM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OCM_STAT_OFS 16'h0005
`define OCM_MODE_OFS 16'h0100
`define OCM_SRST_OFS 16'h0103
`define OCM_FEXT_OFS 16'h0340

// ****************************************************************
// Field values and reset values
// ****************************************************************
`define OCM_MODE_STANDBY 8'h00
`define OCM_MODE_STREAM 8'h01
`define OCM_SRST_GO 8'h01
`define OCM_MODE_BIT 0
`define OCM_MODE_RST 1'b0
`define OCM_FEXT_RST 8'h00
`define OCM_STAT_FIRST_BIT 2

// ****************************************************************
// Frame geometry and timing
// ****************************************************************
`define OCM_MAX_WIDTH 2064
`define OCM_MAX_HEIGHT 1552
`define OCM_H_BLANK 16
`define OCM_V_BLANK 8
`define OCM_EXT_LINES 64
`define OCM_MAX_FPS 20
`define OCM_CLK_HZ 10000000
`define OCM_MIN_FRAME_CYC ((`OCM_CLK_HZ + `OCM_MAX_FPS - 1) / `OCM_MAX_FPS)
`define OCM_LEAK_SHIFT 2

`endif

// ---- hw/ocm_pkg.sv ----
// Types shared by both ends of the operating mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
package ocm_pkg;

    // Device operating state; hardware standby is the reset itself
    typedef enum logic [1:0] {
        ST_SW_STANDBY,
        ST_STREAM,
        ST_DRAIN,
        ST_PADS_OFF
    } ocm_state_t;

    typedef logic [15:0] ocm_addr_t;
    typedef logic [7:0] ocm_byte_t;

endpackage : ocm_pkg

// ---- hw/ocm_link_if.sv ----
// Link between the host controller and the sensor mode controller:
// the active-low shutdown pin plus a request/acknowledge register port.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface ocm_link_if;
    import ocm_pkg::*;

    logic hw_standby_n;
    logic req;
    logic we;
    ocm_addr_t addr;
    ocm_byte_t wdata;
    logic ack;
    ocm_byte_t rdata;

    modport dev (
        input hw_standby_n, req, we, addr, wdata,
        output ack, rdata
    );

    modport host (
        output hw_standby_n, req, we, addr, wdata,
        input ack, rdata
    );

endinterface : ocm_link_if

// ---- hw/ocm_sensor.sv ----
// Sensor end of the operating mode controller: mode state machine, power
// gating, register port, video timing and dark level calibration.
// Assumes REF_CLK is the system clock and the host keeps it running.
`timescale 1ns/100ps
`include "ocm_regs.svh"

module ocm_sensor
    import ocm_pkg::*;
#(
    parameter int H_ACTIVE = `OCM_MAX_WIDTH,
    parameter int V_ACTIVE = `OCM_MAX_HEIGHT,
    parameter int H_BLANK = `OCM_H_BLANK,
    parameter int V_BLANK = `OCM_V_BLANK,
    parameter int EXT_LINES = `OCM_EXT_LINES,
    parameter int MIN_FRAME_CYCLES = `OCM_MIN_FRAME_CYC
) (
    // Clock and power-on reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Host link
    ocm_link_if.dev LINK,
    // Power gating
    output logic CLK_PAD_EN,
    output logic PLL_EN,
    output logic VIDEO_PWR_EN,
    output logic DATA_PAD_OE_N,
    // Pixel array timing
    output logic FRAME_START,
    output logic LINE_VALID,
    output logic [15:0] ROW_ADDR,
    output logic [15:0] COL_ADDR,
    // Dark level calibration
    input wire logic [9:0] DARK_SAMPLE,
    input wire logic DARK_VALID,
    output logic [9:0] DARK_OFFSET
);

    localparam int LINE_LEN = H_ACTIVE + H_BLANK;
    localparam int MIN_LINES = (MIN_FRAME_CYCLES + LINE_LEN - 1) / LINE_LEN;
    localparam int BASE_LINES = (V_ACTIVE + V_BLANK > MIN_LINES) ?
                                (V_ACTIVE + V_BLANK) : MIN_LINES;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Lines in one frame for a given extension setting
    function automatic logic [15:0] frame_lines(input logic [7:0] ext);
        logic [31:0] n;
        n = BASE_LINES + 32'(ext) * EXT_LINES;
        return n[15:0];
    endfunction : frame_lines

    // Leaky integrator step towards a new dark sample
    function automatic logic [9:0] leak(input logic [9:0] cur, input logic [9:0] smp);
        logic signed [11:0] diff;
        logic signed [11:0] sum;
        diff = $signed({2'b00, smp}) - $signed({2'b00, cur});
        sum = $signed({2'b00, cur}) + (diff >>> `OCM_LEAK_SHIFT);
        return sum[9:0];
    endfunction : leak

    // ****************************************************************
    // Reset and register port
    // ****************************************************************

    ocm_state_t state_q;
    logic rst_n;
    logic mode_q;
    logic [7:0] fext_q;
    logic ack_q;
    ocm_byte_t rdata_q;
    logic first_q;
    logic wr_mode;
    logic wr_srst;
    logic frame_end;
    logic [15:0] col_q;
    logic [15:0] row_q;
    logic [9:0] dark_q;
    logic fstart_q;
    logic lv_q;

    // Shutdown pin and power-on reset both clear all logic, clock or not
    assign rst_n = NRST & LINK.hw_standby_n;

    // A request is taken on the first cycle it is seen
    assign wr_mode = LINK.req & ~ack_q & LINK.we & (LINK.addr == `OCM_MODE_OFS);
    assign wr_srst = LINK.req & ~ack_q & LINK.we & (LINK.addr == `OCM_SRST_OFS) &
                     (LINK.wdata == `OCM_SRST_GO);

    // Acknowledge pulse; held in reset so standby never answers
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= LINK.req & ~ack_q;
        end
    end

    // Read data capture
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (LINK.req && !ack_q && !LINK.we) begin
            unique case (LINK.addr)
                `OCM_MODE_OFS: rdata_q <= {7'h00, mode_q};
                `OCM_FEXT_OFS: rdata_q <= fext_q;
                `OCM_STAT_OFS: rdata_q <= {5'h00, first_q, 2'(state_q)};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign LINK.ack = ack_q;
    assign LINK.rdata = rdata_q;

    // Control registers; soft reset restores defaults
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `OCM_MODE_RST;
            fext_q <= `OCM_FEXT_RST;
        end else if (wr_srst) begin
            mode_q <= `OCM_MODE_RST;
            fext_q <= `OCM_FEXT_RST;
        end else if (LINK.req && !ack_q && LINK.we) begin
            if (wr_mode && LINK.wdata == `OCM_MODE_STREAM) begin
                mode_q <= 1'b1;
            end else if (wr_mode && LINK.wdata == `OCM_MODE_STANDBY) begin
                mode_q <= 1'b0;
            end
            if (LINK.addr == `OCM_FEXT_OFS) begin
                fext_q <= LINK.wdata;
            end
        end
    end

    // ****************************************************************
    // Operating mode state machine
    // ****************************************************************

    // Leaves reset in software standby; stop waits for frame end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SW_STANDBY;
        end else if (wr_srst) begin
            state_q <= ST_SW_STANDBY;
        end else begin
            unique case (state_q)
                ST_SW_STANDBY: begin
                    if (mode_q) begin
                        state_q <= ST_STREAM;
                    end
                end
                ST_STREAM: begin
                    if (!mode_q) begin
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (mode_q) begin
                        state_q <= ST_STREAM;
                    end else if (frame_end) begin
                        state_q <= ST_PADS_OFF;
                    end
                end
                ST_PADS_OFF: begin
                    state_q <= ST_SW_STANDBY;
                end
            endcase
        end
    end

    // Power gating decoded from state, clock pad from reset alone; reset means all off
    assign CLK_PAD_EN = rst_n;
    assign PLL_EN = rst_n & (state_q != ST_SW_STANDBY);
    assign VIDEO_PWR_EN = rst_n & (state_q != ST_SW_STANDBY);
    assign DATA_PAD_OE_N = ~(rst_n & (state_q == ST_STREAM || state_q == ST_DRAIN));

    // ****************************************************************
    // Video timing
    // ****************************************************************

    assign frame_end = (col_q == 16'(LINE_LEN - 1)) && (row_q == frame_lines(fext_q) - 16'h0001);

    // Pixel and line counters, held at frame start in software standby and pads off
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= 16'h0000;
            row_q <= 16'h0000;
        end else if (state_q == ST_SW_STANDBY || state_q == ST_PADS_OFF) begin
            col_q <= 16'h0000;
            row_q <= 16'h0000;
        end else if (col_q == 16'(LINE_LEN - 1)) begin
            col_q <= 16'h0000;
            row_q <= frame_end ? 16'h0000 : row_q + 16'h0001;
        end else begin
            col_q <= col_q + 16'h0001;
        end
    end

    // Registered array strobes limited to the active window
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fstart_q <= 1'b0;
            lv_q <= 1'b0;
        end else begin
            fstart_q <= (state_q == ST_STREAM) && col_q == 16'h0000 && row_q == 16'h0000;
            lv_q <= (state_q == ST_STREAM || state_q == ST_DRAIN) &&
                    col_q < 16'(H_ACTIVE) && row_q < 16'(V_ACTIVE);
        end
    end

    assign FRAME_START = fstart_q;
    assign LINE_VALID = lv_q;
    assign ROW_ADDR = row_q;
    assign COL_ADDR = col_q;

    // ****************************************************************
    // Dark level calibration
    // ****************************************************************

    // First sample after standby is taken whole, later ones damped
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
            dark_q <= 10'h000;
        end else if (state_q == ST_SW_STANDBY) begin
            first_q <= 1'b1;
        end else if (DARK_VALID) begin
            first_q <= 1'b0;
            dark_q <= first_q ? DARK_SAMPLE : leak(dark_q, DARK_SAMPLE);
        end
    end

    assign DARK_OFFSET = dark_q;

endmodule : ocm_sensor

// ---- hw/ocm_host.sv ----
// Host end of the operating mode controller: drives the shutdown pin and
// turns user commands into register transactions on the link.
// Assumes REF_CLK is also the sensor's system clock.
`timescale 1ns/100ps
`include "ocm_regs.svh"

module ocm_host
    import ocm_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Host link
    ocm_link_if.host LINK,
    // Shutdown control
    input wire logic HW_STANDBY_REQ,
    // User command port
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire ocm_addr_t CMD_ADDR,
    input wire ocm_byte_t CMD_WDATA,
    output logic CMD_READY,
    output logic RSP_VALID,
    output ocm_byte_t RSP_RDATA
);

    logic sd_n_q;
    logic busy_q;
    logic we_q;
    ocm_addr_t addr_q;
    ocm_byte_t wdata_q;
    logic rsp_q;
    ocm_byte_t rdata_q;

    // Shutdown pin follows the user request, low from reset
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sd_n_q <= 1'b0;
        end else begin
            sd_n_q <= ~HW_STANDBY_REQ;
        end
    end

    // No command while the sensor is in hardware standby
    assign CMD_READY = ~busy_q & sd_n_q & ~HW_STANDBY_REQ;

    // Request held until acknowledge; dropped if shutdown intervenes
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            busy_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else if (busy_q) begin
            if (LINK.ack || !sd_n_q) begin
                busy_q <= 1'b0;
            end
        end else if (CMD_VALID && CMD_READY) begin
            busy_q <= 1'b1;
            we_q <= CMD_WRITE;
            addr_q <= CMD_ADDR;
            wdata_q <= CMD_WDATA;
        end
    end

    // Response pulse with read data
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rsp_q <= busy_q & LINK.ack;
            if (busy_q && LINK.ack) begin
                rdata_q <= LINK.rdata;
            end
        end
    end

    assign LINK.hw_standby_n = sd_n_q;
    assign LINK.req = busy_q;
    assign LINK.we = we_q;
    assign LINK.addr = addr_q;
    assign LINK.wdata = wdata_q;
    assign RSP_VALID = rsp_q;
    assign RSP_RDATA = rdata_q;

endmodule : ocm_host

// ---- verif/ocm_link_props.sv ----
// Checker for the register link between host and sensor ends.
// Assumes it sees the link signals plus the shared clock and reset.
`timescale 1ns/100ps
`include "ocm_regs.svh"

module ocm_link_props
    import ocm_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Link signals
    input wire logic hw_standby_n,
    input wire logic req,
    input wire logic we,
    input wire ocm_addr_t addr,
    input wire ocm_byte_t wdata,
    input wire logic ack,
    input wire ocm_byte_t rdata
);
    logic dev_rst_n;
    logic mode_q;
    logic mapped;

    // Sensor reset follows the pin as well as power-on reset
    assign dev_rst_n = NRST & hw_standby_n;
    assign mapped = addr == `OCM_STAT_OFS || addr == `OCM_MODE_OFS ||
                    addr == `OCM_SRST_OFS || addr == `OCM_FEXT_OFS;

    // Mode value the sensor should hold, from accepted writes
    always_ff @(posedge REF_CLK or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            mode_q <= 1'b0;
        end else if (ack && we && addr == `OCM_MODE_OFS && wdata[7:1] == 7'h00) begin
            mode_q <= wdata[0];
        end else if (ack && we && addr == `OCM_SRST_OFS && wdata == `OCM_SRST_GO) begin
            mode_q <= 1'b0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    chk_standby_no_ack: assert property (!hw_standby_n |-> !ack)
        else $error("ack seen in hardware standby");
    chk_ack_one_cycle: assert property (req && !ack && hw_standby_n ##1 hw_standby_n |-> ack)
        else $error("request not answered in one cycle");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_ack_has_req: assert property (ack |-> $past(req) && !$past(ack))
        else $error("ack without a taken request");
    chk_req_held: assert property (req && !ack && hw_standby_n ##1 hw_standby_n
        |-> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    chk_req_drops: assert property (ack |=> !req)
        else $error("request held after ack");
    chk_mode_readback: assert property (ack && !we && addr == `OCM_MODE_OFS
        |-> rdata == {7'h00, mode_q})
        else $error("mode register read back wrong");
    chk_srst_reads_zero: assert property (ack && !we && addr == `OCM_SRST_OFS
        |-> rdata == 8'h00)
        else $error("soft reset register not zero");
    chk_unmapped_zero: assert property (ack && !we && !mapped |-> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : ocm_link_props

// ---- verif/testbench.sv ----
// Self-checking bench: host and sensor ends joined by the link.
// Assumes a shrunk frame: 8x4 active, 2 and 1 blank, 20 cycle minimum.
`timescale 1ns/100ps
`include "ocm_regs.svh"

module testbench;
    import ocm_pkg::*;
    localparam int FRAME_CYC = (8 + 2) * (4 + 1);
    localparam int FRAME_EXT_CYC = FRAME_CYC + `OCM_EXT_LINES * (8 + 2);
    logic ref_clk = 1'b0;
    logic nrst, hw_req, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    ocm_addr_t cmd_addr;
    ocm_byte_t cmd_wdata, rsp_rdata, r;
    logic clk_pad_en, pll_en, video_pwr_en, data_pad_oe_n, frame_start, line_valid;
    logic [15:0] row_addr, col_addr;
    logic [9:0] dark_sample, dark_offset;
    logic dark_valid;
    int err_count = 0;
    int checked = 0;
    int n, cyc, last, per, lv_cnt, lv_last;

    // ****************************************************************
    // Clock, design ends and checker
    // ****************************************************************
    always #50 ref_clk = ~ref_clk;
    ocm_link_if i_ocm_link_if ();
    ocm_sensor #(.H_ACTIVE(8), .V_ACTIVE(4), .H_BLANK(2), .V_BLANK(1),
        .MIN_FRAME_CYCLES(20)) i_ocm_sensor (.REF_CLK(ref_clk), .NRST(nrst),
        .LINK(i_ocm_link_if.dev), .CLK_PAD_EN(clk_pad_en), .PLL_EN(pll_en),
        .VIDEO_PWR_EN(video_pwr_en), .DATA_PAD_OE_N(data_pad_oe_n),
        .FRAME_START(frame_start), .LINE_VALID(line_valid), .ROW_ADDR(row_addr),
        .COL_ADDR(col_addr), .DARK_SAMPLE(dark_sample), .DARK_VALID(dark_valid),
        .DARK_OFFSET(dark_offset));
    ocm_host i_ocm_host (.REF_CLK(ref_clk), .NRST(nrst), .LINK(i_ocm_link_if.host),
        .HW_STANDBY_REQ(hw_req), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
        .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
    ocm_link_props i_ocm_link_props (.REF_CLK(ref_clk), .NRST(nrst),
        .hw_standby_n(i_ocm_link_if.hw_standby_n), .req(i_ocm_link_if.req),
        .we(i_ocm_link_if.we), .addr(i_ocm_link_if.addr), .wdata(i_ocm_link_if.wdata),
        .ack(i_ocm_link_if.ack), .rdata(i_ocm_link_if.rdata));

    // Frame period and active pixel count between frame starts
    always @(posedge ref_clk) begin
        cyc++;
        if (frame_start === 1'b1) begin
            per = cyc - last;
            last = cyc;
            lv_last = lv_cnt;
            lv_cnt = (line_valid === 1'b1);
        end else begin
            lv_cnt += (line_valid === 1'b1);
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic give_verdict();
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic tick();
        @(posedge ref_clk);
        #10;
    endtask : tick

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Wait one step for a signal, giving up after 60 steps
    task automatic step(input logic s, input string nm);
        tick();
        n++;
        if (n > 60) begin
            chk(nm, 16'h0001, {15'h0000, s});
            give_verdict();
        end
    endtask : step

    task automatic xfer(input logic w, input ocm_addr_t a, input ocm_byte_t d);
        n = 0;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1) step(cmd_ready, "cmd_ready");
        tick();
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) step(rsp_valid, "rsp_valid");
        r = rsp_rdata;
    endtask : xfer

    task automatic rd_chk(input ocm_addr_t a, input ocm_byte_t e);
        xfer(1'b0, a, 8'h00);
        chk("read", {8'h00, e}, {8'h00, r});
    endtask : rd_chk

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {nrst, hw_req, cmd_valid, cmd_write, dark_valid} = 5'h00;
        cmd_addr = 16'h0000;
        cmd_wdata = 8'h00;
        dark_sample = 10'h000;
        repeat (6) @(posedge ref_clk);
        #10;
        nrst = 1'b1;
        repeat (3) tick();
        chk("pads", 16'h0001, {15'h0000, data_pad_oe_n});
        chk("clk_pad", 16'h0001, {15'h0000, clk_pad_en});
        rd_chk(`OCM_MODE_OFS, 8'h00);
        xfer(1'b1, `OCM_MODE_OFS, 8'h02);
        rd_chk(`OCM_MODE_OFS, 8'h00);
        rd_chk(16'h0200, 8'h00);
        xfer(1'b1, `OCM_MODE_OFS, `OCM_MODE_STREAM);
        chk("pads", 16'h0000, {15'h0000, data_pad_oe_n});
        chk("pll", 16'h0001, {15'h0000, pll_en & video_pwr_en});
        rd_chk(`OCM_MODE_OFS, 8'h01);
        repeat (130) tick();
        chk("period", 16'(FRAME_CYC), per[15:0]);
        chk("active", 16'd32, lv_last[15:0]);
        xfer(1'b1, `OCM_MODE_OFS, `OCM_MODE_STANDBY);
        chk("pads", 16'h0000, {15'h0000, data_pad_oe_n});
        n = 0;
        while (data_pad_oe_n !== 1'b1) step(data_pad_oe_n, "pads");
        chk("pll", 16'h0001, {15'h0000, pll_en});
        tick();
        chk("pll", 16'h0000, {15'h0000, pll_en | video_pwr_en});
        chk("row", 16'h0000, row_addr | col_addr);
        xfer(1'b1, `OCM_MODE_OFS, `OCM_MODE_STREAM);
        repeat (20) tick();
        // Frame extension takes effect within the running frame
        xfer(1'b1, `OCM_FEXT_OFS, 8'h01);
        rd_chk(`OCM_FEXT_OFS, 8'h01);
        repeat (1450) tick();
        chk("period", 16'(FRAME_EXT_CYC), per[15:0]);
        xfer(1'b1, `OCM_SRST_OFS, `OCM_SRST_GO);
        chk("pads", 16'h0001, {15'h0000, data_pad_oe_n});
        rd_chk(`OCM_MODE_OFS, 8'h00);
        rd_chk(`OCM_SRST_OFS, 8'h00);
        rd_chk(`OCM_FEXT_OFS, `OCM_FEXT_RST);
        rd_chk(`OCM_STAT_OFS, 8'(1 << `OCM_STAT_FIRST_BIT));
        xfer(1'b1, `OCM_MODE_OFS, `OCM_MODE_STREAM);
        // Shutdown rises just after a read is taken: no answer may follow
        chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
        cmd_valid = 1'b1;
        cmd_write = 1'b0;
        cmd_addr = `OCM_MODE_OFS;
        tick();
        cmd_valid = 1'b0;
        hw_req = 1'b1;
        repeat (4) begin
            tick();
            chk("rsp_valid", 16'h0000, {15'h0000, rsp_valid});
        end
        chk("clk_pad", 16'h0000, {15'h0000, clk_pad_en | pll_en | video_pwr_en});
        chk("pads", 16'h0001, {15'h0000, data_pad_oe_n});
        chk("cmd_ready", 16'h0000, {15'h0000, cmd_ready});
        hw_req = 1'b0;
        repeat (2) tick();
        rd_chk(`OCM_MODE_OFS, 8'h00);
        xfer(1'b1, `OCM_MODE_OFS, `OCM_MODE_STREAM);
        dark_sample = 10'd400;
        dark_valid = 1'b1;
        tick();
        dark_valid = 1'b0;
        tick();
        chk("dark", 16'd400, {6'h00, dark_offset});
        dark_sample = 10'd0;
        dark_valid = 1'b1;
        tick();
        dark_valid = 1'b0;
        tick();
        chk("dark", 16'd300, {6'h00, dark_offset});
        give_verdict();
    end
endmodule : testbench
